// file: design/ufscr_params.svh
// Constants of the bus supervision register bank: register indices, address width,
// field positions and reset values. Assumes a 32-bit APB data path, one register per word.
`ifndef UFSCR_PARAMS_SVH
`define UFSCR_PARAMS_SVH

// Register indices; the byte address is four times the index
`define UFSCR_IDX_MODE 16'hFFFB
`define UFSCR_IDX_CTL 16'hFFFC
`define UFSCR_IDX_MSK 16'hFFFD
`define UFSCR_IDX_STA 16'hFFFE
`define UFSCR_ADDR_W 18

// Status and mask bit positions
`define UFSCR_STA_OVERRUN 0
`define UFSCR_STA_WAKE 1
`define UFSCR_STA_SETUP 2
`define UFSCR_STA_RING 3
`define UFSCR_STA_RSV 4
`define UFSCR_STA_RESUME 5
`define UFSCR_STA_SUSPEND 6
`define UFSCR_STA_BUSRST 7

// Control bit positions
`define UFSCR_CTL_DIR 0
`define UFSCR_CTL_SERVICE 1
`define UFSCR_CTL_RSV2 2
`define UFSCR_CTL_RSV3 3
`define UFSCR_CTL_LINK 4
`define UFSCR_CTL_WAKE 5
`define UFSCR_CTL_IR 6
`define UFSCR_CTL_ATTACH 7

// Mode bit positions
`define UFSCR_MODE_TXSEL 0
`define UFSCR_MODE_SERIAL_OUT_DISABLE 1
`define UFSCR_MODE_CLKEN 2
`define UFSCR_MODE_CLKSRC 3

// Reset values and writable masks
`define UFSCR_STA_RST 8'h00
`define UFSCR_MSK_RST 8'h00
`define UFSCR_CTL_RST 8'h10
`define UFSCR_MODE_RST 8'h00
`define UFSCR_STA_USED 8'hEF
`define UFSCR_CTL_WMASK 8'hD3
`define UFSCR_MODE_WMASK 8'h0F

// Synchronised pin positions
`define UFSCR_PIN_RING 0
`define UFSCR_PIN_BAUD 1
`define UFSCR_PIN_FIXED 2
`define UFSCR_PIN_N 3

`endif

// file: design/ufscr_pkg.sv
// Types shared by the bus supervision register bank.
// Assumes the USB engine delivers its events as one-cycle pulses on clk.
`default_nettype none

package ufscr_pkg;

    // Event pulses from the USB engine, one cycle each
    typedef struct packed {
        logic setup_rx;     // Setup transaction received
        logic wake_evt;     // Remote wakeup event
        logic resume_det;   // Resume after suspend
        logic suspend_det;  // Global or selective suspend
        logic bus_reset_det; // Host port reset seen
    } ufscr_evt_s;

    // Decoded register select
    typedef enum logic [2:0] {
        UFSCR_SEL_NONE,
        UFSCR_SEL_MODE,
        UFSCR_SEL_CTL,
        UFSCR_SEL_MSK,
        UFSCR_SEL_STA
    } ufscr_sel_e;

    typedef logic [7:0] ufscr_byte_t;

endpackage

`default_nettype wire

// file: design/ufscr_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to clk; output settles three to four cycles late.
`default_nettype none

module ufscr_sync #(
    parameter int W = 3
) (
    input wire logic clk,             // Core clock
    input wire logic rst_n,           // Async reset, active low
    input wire logic [W-1:0] pin_in,  // Raw pins
    output logic [W-1:0] level_out    // Filtered level
);
    import ufscr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_lane
            logic s1_r;
            logic s2_r;
            logic s3_r;
            // First stage feeds only the second; level moves once 2 and 3 agree
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    level_out[gi] <= 1'b0;
                end else begin
                    s1_r <= pin_in[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        level_out[gi] <= s3_r;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: design/ufscr_regs.sv
// Bus supervision register bank: event status, interrupt mask, control and output mode.
// Assumes an APB master on clk, event pulses from the USB engine on clk, and raw pins
// for ring indicate and the two candidate output clocks.
//
// Summary of operation
// (R1) Status flags are set by hardware; writing 1 clears, writing 0 keeps.
// (R2) A flag raises the interrupt only while its mask bit is set; masks reset clear.
// (R3) Setup arriving while setup flag still set sets the overwrite flag, bit 0.
// (R4) Setup received sets bit 2; while set, endpoint zero answers NAK.
// (R5) Rising edge of ring indicate sets bit 3, usable to leave suspend.
// (R6) Resume after suspension sets bit 5.
// (R7) Global or selective suspend sets bit 6.
// (R8) Host port reset sets bit 7.
// (R9) Control and mode registers clear only on power-up reset, never on bus reset.
// (R10) Firmware writes control bit 0 with data stage direction, 1 meaning IN.
// (R11) Firmware holds control bit 1 high while servicing the setup interrupt.
// (R12) Control bit 3 is written as 0; bit 2 reads as 0.
// (R13) Control bit 4, reset 1, links bus reset to microcontroller reset.
// (R14) Control bit 5 requests remote wakeup; hardware clears it, writing 0 ignored.
// (R15) Control bit 6 selects infrared coding when 1, plain UART when 0.
// (R16) Mode bit 0 selects hardware (0) or firmware (1) serial buffer switching.
// (R17) Mode bit 1 at 0 lets the buffer drive; at 1 disables it.
// (R18) Mode bit 3 picks the clock pin source: fixed clock or baud clock.
// (R19) Clock source 0 routes baud clock, 1 routes the fixed clock.
// (R20) Mode bit 2 enables the clock pin; disabled it is held low.
// (R21) Internal reset from power-up or linked bus reset clears all but control/mode; linked bus reset keeps mask bit 7.
// (R22) Control bit 7 at 1 enables the data line pullup, 0 disconnects.
// (R23) Remote wakeup event sets status bit 1, cleared by writing 1.
`default_nettype none
`include "ufscr_params.svh"

module ufscr_regs (
    input wire logic clk,                         // 250 MHz core clock
    input wire logic rst_n,                       // Power-up reset, async, active low
    input wire logic psel,                        // APB select
    input wire logic penable,                     // APB access phase
    input wire logic pwrite,                      // APB direction
    input wire logic [`UFSCR_ADDR_W-1:0] paddr,   // APB byte address
    input wire logic [31:0] pwdata,               // APB write data
    input wire logic [3:0] pstrb,                 // APB byte strobes
    output logic [31:0] prdata,                   // APB read data
    output logic pready,                          // APB ready
    output logic pslverr,                         // APB error, unmapped address
    input wire ufscr_pkg::ufscr_evt_s evt,        // Engine event pulses
    input wire logic bus_reset_signal,            // Bus reset level from engine
    input wire logic wake_done,                   // Wakeup signalling finished
    input wire logic ring_pin,                    // Ring indicate pin
    input wire logic baud_clk_pin,                // UART baud-out clock
    input wire logic fixed_clk_pin,               // Fixed free-running clock
    input wire logic tx_auto_oe,                  // UART automatic buffer enable
    output logic irq,                             // Interrupt to microcontroller
    output logic ep0_force_nak,                   // NAK all endpoint zero traffic
    output logic data_dir_in,                     // Data stage direction, 1 = IN
    output logic setup_in_service,                // Firmware servicing setup
    output logic mcu_reset,                       // Reset toward microcontroller
    output logic wake_request,                    // Remote wakeup request
    output logic infrared_mode_select,            // Infrared coding active
    output logic bus_attach,                      // Data line pullup enable
    output logic serial_out_oe,                   // Serial output buffer enable
    output logic clock_pin                        // Clock output pin
);
    import ufscr_pkg::*;

    // All checks below run on clk and sleep through power-up reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    ufscr_byte_t status_r;
    ufscr_byte_t mask_r;
    ufscr_byte_t ctl_r;
    ufscr_byte_t mode_r;
    ufscr_byte_t set_vec;
    ufscr_byte_t wdata8;
    ufscr_byte_t rd_byte;
    ufscr_sel_e sel;
    logic [`UFSCR_PIN_N-1:0] pins_raw;
    logic [`UFSCR_PIN_N-1:0] pins_lvl;
    logic ring_prev_r;
    logic ring_rise;
    logic int_reset;
    logic acc_done;
    logic wr_sta;
    logic wr_msk;
    logic wr_ctl;
    logic wr_mode;
    logic [15:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign pins_raw = {fixed_clk_pin, baud_clk_pin, ring_pin};

    ufscr_sync #(.W(`UFSCR_PIN_N)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pins_raw),
        .level_out(pins_lvl)
    );

    // Ring edge taken on the filtered level so glitches count once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_prev_r <= 1'b0;
        end else begin
            ring_prev_r <= pins_lvl[`UFSCR_PIN_RING];
        end
    end
    assign ring_rise = pins_lvl[`UFSCR_PIN_RING] & ~ring_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; only the low byte lane carries register data
    assign idx = paddr[`UFSCR_ADDR_W-1:2];
    always_comb begin
        sel = UFSCR_SEL_NONE;
        if (paddr[1:0] == 2'h0) begin
            case (idx)
                `UFSCR_IDX_MODE: sel = UFSCR_SEL_MODE;
                `UFSCR_IDX_CTL: sel = UFSCR_SEL_CTL;
                `UFSCR_IDX_MSK: sel = UFSCR_SEL_MSK;
                `UFSCR_IDX_STA: sel = UFSCR_SEL_STA;
                default: sel = UFSCR_SEL_NONE;
            endcase
        end
    end

    // Writes land only at the completing access edge
    assign acc_done = psel & penable & pready;
    assign wdata8 = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign wr_sta = acc_done & pwrite & (sel == UFSCR_SEL_STA);
    assign wr_msk = acc_done & pwrite & pstrb[0] & (sel == UFSCR_SEL_MSK);
    assign wr_ctl = acc_done & pwrite & pstrb[0] & (sel == UFSCR_SEL_CTL);
    assign wr_mode = acc_done & pwrite & pstrb[0] & (sel == UFSCR_SEL_MODE);

    always_comb begin
        case (sel)
            UFSCR_SEL_MODE: rd_byte = mode_r & `UFSCR_MODE_WMASK;
            UFSCR_SEL_CTL: rd_byte = ctl_r & 8'hF3;
            UFSCR_SEL_MSK: rd_byte = mask_r & `UFSCR_STA_USED;
            UFSCR_SEL_STA: rd_byte = status_r & `UFSCR_STA_USED;
            default: rd_byte = 8'h00;
        endcase
    end

    // No wait state: data and ready are registered in the setup cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & (sel == UFSCR_SEL_NONE);
            if (psel & ~penable & ~pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal reset: linked bus reset clears status except flags set in that cycle, and clears mask bits 6 to 0 unless a mask write lands
    assign int_reset = bus_reset_signal & ctl_r[`UFSCR_CTL_LINK]; // R13 R21

    // Hardware set terms
    always_comb begin
        set_vec = 8'h00;
        set_vec[`UFSCR_STA_OVERRUN] = evt.setup_rx & status_r[`UFSCR_STA_SETUP]; // R3
        set_vec[`UFSCR_STA_WAKE] = evt.wake_evt; // R23
        set_vec[`UFSCR_STA_SETUP] = evt.setup_rx; // R4
        set_vec[`UFSCR_STA_RING] = ring_rise; // R5
        set_vec[`UFSCR_STA_RESUME] = evt.resume_det; // R6
        set_vec[`UFSCR_STA_SUSPEND] = evt.suspend_det; // R7
        set_vec[`UFSCR_STA_BUSRST] = evt.bus_reset_det; // R8
    end

    // Status: write-one-to-clear, a set in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= `UFSCR_STA_RST;
        end else if (int_reset) begin
            status_r <= set_vec; // R21
        end else if (wr_sta) begin
            status_r <= ((status_r & ~wdata8) | set_vec) & `UFSCR_STA_USED; // R1
        end else begin
            status_r <= (status_r | set_vec) & `UFSCR_STA_USED;
        end
    end

    // Mask: the bus reset mask bit survives a function reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= `UFSCR_MSK_RST; // R2
        end else if (wr_msk) begin
            mask_r <= wdata8 & `UFSCR_STA_USED;
        end else if (int_reset) begin
            mask_r <= mask_r & 8'h80; // R21
        end
    end

    // Control: power-up reset only; reserved bits never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= `UFSCR_CTL_RST; // R9 R13
        end else begin
            if (wr_ctl) begin
                ctl_r[`UFSCR_CTL_DIR] <= wdata8[`UFSCR_CTL_DIR]; // R10
                ctl_r[`UFSCR_CTL_SERVICE] <= wdata8[`UFSCR_CTL_SERVICE]; // R11
                ctl_r[`UFSCR_CTL_LINK] <= wdata8[`UFSCR_CTL_LINK];
                ctl_r[`UFSCR_CTL_IR] <= wdata8[`UFSCR_CTL_IR]; // R15
                ctl_r[`UFSCR_CTL_ATTACH] <= wdata8[`UFSCR_CTL_ATTACH]; // R22
            end
            // Firmware set beats the hardware clear of the same cycle
            if (wr_ctl & wdata8[`UFSCR_CTL_WAKE]) begin
                ctl_r[`UFSCR_CTL_WAKE] <= 1'b1; // R14
            end else if (wake_done) begin
                ctl_r[`UFSCR_CTL_WAKE] <= 1'b0; // R14
            end
            ctl_r[`UFSCR_CTL_RSV2] <= 1'b0; // R12
            ctl_r[`UFSCR_CTL_RSV3] <= 1'b0; // R12
        end
    end

    // Mode: power-up reset only, upper nibble reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= `UFSCR_MODE_RST; // R9
        end else if (wr_mode) begin
            mode_r <= wdata8 & `UFSCR_MODE_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and endpoint zero outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            ep0_force_nak <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r); // R2
            ep0_force_nak <= status_r[`UFSCR_STA_SETUP]; // R4
        end
    end

    // Control field outputs and reset linkage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_dir_in <= 1'b0;
            setup_in_service <= 1'b0;
            mcu_reset <= 1'b0;
            wake_request <= 1'b0;
            infrared_mode_select <= 1'b0;
            bus_attach <= 1'b0;
        end else begin
            data_dir_in <= ctl_r[`UFSCR_CTL_DIR]; // R10
            setup_in_service <= ctl_r[`UFSCR_CTL_SERVICE]; // R11
            mcu_reset <= int_reset; // R13
            wake_request <= ctl_r[`UFSCR_CTL_WAKE]; // R14
            infrared_mode_select <= ctl_r[`UFSCR_CTL_IR]; // R15
            bus_attach <= ctl_r[`UFSCR_CTL_ATTACH]; // R22
        end
    end

    // Serial buffer and clock pin; pin clocks lag by the synchroniser depth
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_oe <= 1'b0;
            clock_pin <= 1'b0;
        end else begin
            if (mode_r[`UFSCR_MODE_TXSEL]) begin
                serial_out_oe <= ~mode_r[`UFSCR_MODE_SERIAL_OUT_DISABLE]; // R16 R17
            end else begin
                serial_out_oe <= tx_auto_oe; // R16
            end
            if (!mode_r[`UFSCR_MODE_CLKEN]) begin
                clock_pin <= 1'b0; // R20
            end else if (mode_r[`UFSCR_MODE_CLKSRC]) begin
                clock_pin <= pins_lvl[`UFSCR_PIN_FIXED]; // R18 R19
            end else begin
                clock_pin <= pins_lvl[`UFSCR_PIN_BAUD]; // R19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_apb_access;
        psel && penable && pready;
    endsequence

    a_apb_one_wait: assert property (s_apb_setup |=> pready)
        else $error("APB ready not one cycle after setup");
    a_w1c_clear: assert property (wr_sta && !int_reset |=> // R1
        (status_r & $past(wdata8) & ~$past(set_vec)) == 8'h00)
        else $error("Status bit not cleared by write of one");
    a_zero_keep: assert property (wr_sta && !int_reset |=> // R1
        (status_r & $past(status_r) & ~$past(wdata8)) == ($past(status_r) & ~$past(wdata8)))
        else $error("Status bit lost on write of zero");
    // A flag set in the cycle of its clearing write must survive
    a_set_wins: assert property (wr_sta && evt.wake_evt |=> status_r[1]) // R1 R23
        else $error("Wakeup flag lost to a same-cycle clear");
    a_irq_mask: assert property (##1 irq == |($past(status_r) & $past(mask_r))) // R2
        else $error("Interrupt does not follow masked status");
    a_overrun_set: assert property (evt.setup_rx && status_r[2] |=> status_r[0]) // R3
        else $error("Setup overwrite not flagged");
    a_setup_nak: assert property (evt.setup_rx |=> status_r[2] ##1 ep0_force_nak) // R4
        else $error("Endpoint zero not forced to NAK after setup");
    a_ring_flag: assert property (ring_rise |=> status_r[3]) // R5
        else $error("Ring edge not flagged");
    a_resume_flag: assert property (evt.resume_det |=> status_r[5]) // R6
        else $error("Resume not flagged");
    a_suspend_flag: assert property (evt.suspend_det |=> status_r[6]) // R7
        else $error("Suspend not flagged");
    a_busrst_flag: assert property (evt.bus_reset_det |=> status_r[7]) // R8
        else $error("Bus reset not flagged");
    a_ctl_survives: assert property (int_reset && !wr_ctl && !wr_mode |=> // R9
        $stable(ctl_r[7:6]) && $stable(ctl_r[4:0]) && $stable(mode_r))
        else $error("Control or mode changed by bus reset");
    a_mask_keep: assert property (int_reset && !wr_msk |=> mask_r[6:0] == 7'h00 && $stable(mask_r[7])) // R21
        else $error("Mask not cleared by internal reset");
    a_link_reset: assert property (bus_reset_signal && ctl_r[4] |=> // R13 R21
        mcu_reset && (status_r[4:0] & ~$past(set_vec[4:0])) == 5'h00)
        else $error("Linked bus reset not passed on");
    a_wake_auto: assert property (wake_done && !wr_ctl |=> !ctl_r[5] ##1 !wake_request) // R14
        else $error("Wakeup request not cleared by hardware");
    a_wake_keep: assert property (wr_ctl && !wdata8[5] && !wake_done |=> $stable(ctl_r[5])) // R14
        else $error("Wakeup request changed by a write of zero");
    a_tx_soft: assert property (mode_r[0] ##1 mode_r[0] |-> serial_out_oe == !$past(mode_r[1])) // R16
        else $error("Serial buffer not under firmware switch");
    a_clk_low: assert property (!mode_r[2] |=> !clock_pin) // R20
        else $error("Disabled clock pin not held low");
    a_wake_evt: assert property (s_apb_access ##0 evt.wake_evt |=> status_r[1]) // R23
        else $error("Wakeup event lost during access");

endmodule

`default_nettype wire

// file: design/_unused_guard_note.sv
`default_nettype none
`default_nettype wire

// file: test/ufscr_engine_model.sv
// Behavioural USB engine and clock sources facing the register bank.
// Assumes the bench requests events one cycle ahead on clk.
`default_nettype none

module ufscr_engine_model (
    input wire logic clk,               // Core clock
    input wire logic rst_n,             // Reset, active low
    input wire logic [4:0] req,         // Event request from bench
    output ufscr_pkg::ufscr_evt_s evt,  // One-cycle event pulses
    output logic baud_clk_pin,          // Slow baud-out clock
    output logic fixed_clk_pin          // Fast free-running clock
);
    import ufscr_pkg::*;

    logic [4:0] div_r;

    // Pulses last one cycle; clocks run free so source selection can be told apart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt <= '0;
            div_r <= 5'h00;
        end else begin
            evt <= ufscr_evt_s'(req);
            div_r <= div_r + 5'h01;
        end
    end

    // Half periods of 8 and 16 cycles outlast the pin filter
    assign fixed_clk_pin = div_r[3];
    assign baud_clk_pin = div_r[4];
endmodule

`default_nettype wire

// file: test/usb_function_status_control_regs_tb.sv
// Self-checking bench for the bus supervision register bank over APB.
// Assumes the engine model and design sources are compiled first.
`default_nettype none
`include "ufscr_params.svh"

module usb_function_status_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ufscr_pkg::*;

    localparam logic [17:0] A_MODE = {`UFSCR_IDX_MODE, 2'b00};
    localparam logic [17:0] A_CTL = {`UFSCR_IDX_CTL, 2'b00};
    localparam logic [17:0] A_MSK = {`UFSCR_IDX_MSK, 2'b00};
    localparam logic [17:0] A_STA = {`UFSCR_IDX_STA, 2'b00};
    localparam int POS [5] = '{7, 6, 5, 1, 2};

    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, ep0_force_nak;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb;
    logic [4:0] req;
    ufscr_evt_s evt;
    logic bus_reset_signal, wake_done, ring_pin, baud_clk_pin, fixed_clk_pin, tx_auto_oe;
    logic data_dir_in, setup_in_service, mcu_reset, wake_request, infrared_mode_select;
    logic bus_attach, serial_out_oe, clock_pin, err;
    int err_total, checks, cnt;
    logic [7:0] c;

    ufscr_engine_model eng (.clk, .rst_n, .req, .evt, .baud_clk_pin, .fixed_clk_pin);
    ufscr_regs uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .evt, .bus_reset_signal, .wake_done, .ring_pin, .baud_clk_pin,
        .fixed_clk_pin, .tx_auto_oe, .irq, .ep0_force_nak, .data_dir_in, .setup_in_service,
        .mcu_reset, .wake_request, .infrared_mode_select, .bus_attach, .serial_out_oe, .clock_pin);

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // No local limit: only the watchdog ends a stalled wait
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [17:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        check("read", rv, {24'h000000, e});
        check("slverr", err, 1'b0);
    endtask

    task automatic fire(input logic [4:0] b);
        @(posedge clk) req <= b;
        @(posedge clk) req <= 5'h00;
        repeat (3) @(posedge clk);
    endtask

    task automatic edges(input int len);
        logic p;
        cnt = 0;
        p = clock_pin;
        repeat (len) begin
            @(posedge clk);
            if (clock_pin !== p) cnt++;
            p = clock_pin;
        end
    endtask

    // Hang guard
    initial begin
        #200us;
        err_total++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, req, bus_reset_signal, wake_done} = '0;
        {ring_pin, tx_auto_oe, err_total, checks} = '0;
        pstrb = 4'hF;
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and unmapped access
        rdc(A_MODE, 8'h00);
        rdc(A_CTL, 8'h10);
        rdc(A_MSK, 8'h00);
        rdc(A_STA, 8'h00);
        apb(1'b0, 18'h00010, 8'h00);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rv, 32'h0000_0000);
        // Each event sets its flag; writing 0 keeps, writing 1 clears
        for (int i = 0; i < 5; i++) begin
            fire(5'h01 << i);
            wr(A_STA, 8'h00);
            rdc(A_STA, 8'h01 << POS[i]);
            if (i == 4) begin
                check("nak", ep0_force_nak, 1'b1);
                fire(5'h10);
                rdc(A_STA, 8'h05);
                wr(A_STA, 8'h01);
            end
            wr(A_STA, 8'h01 << POS[i]);
            rdc(A_STA, 8'h00);
        end
        check("nak off", ep0_force_nak, 1'b0);
        // Wakeup pulse lands on the very edge of a clearing write; the set wins
        fork
            fire(5'h08);
            wr(A_STA, 8'h02);
        join
        rdc(A_STA, 8'h02);
        wr(A_STA, 8'h02);
        // Masked interrupt
        fire(5'h02);
        check("irq masked", irq, 1'b0);
        wr(A_MSK, 8'h40);
        repeat (2) @(posedge clk);
        check("irq", irq, 1'b1);
        wr(A_MSK, 8'h00);
        repeat (2) @(posedge clk);
        check("irq off", irq, 1'b0);
        wr(A_STA, 8'h40);
        // Ring edge
        ring_pin <= 1'b1;
        repeat (10) @(posedge clk);
        rdc(A_STA, 8'h08);
        wr(A_STA, 8'h08);
        // Control fields, firmware keeps bit 3 at 0
        wr(A_CTL, 8'hE3);
        rdc(A_CTL, 8'hE3);
        check("outs", {data_dir_in, setup_in_service, wake_request, infrared_mode_select, bus_attach},
            5'h1F);
        wr(A_CTL, 8'hC3);
        rdc(A_CTL, 8'hE3);
        @(posedge clk) wake_done <= 1'b1;
        @(posedge clk) wake_done <= 1'b0;
        rdc(A_CTL, 8'hC3);
        wr(A_CTL, 8'h04);
        rdc(A_CTL, 8'h00);
        // Bus reset with link off, then on
        wr(A_MODE, 8'h05);
        for (int k = 0; k < 2; k++) begin
            c = k ? 8'h10 : 8'h00;
            wr(A_MSK, 8'hEF);
            wr(A_CTL, c);
            fire(5'h02);
            @(posedge clk) bus_reset_signal <= 1'b1;
            repeat (3) @(posedge clk);
            check("mcu rst", mcu_reset, c[4]);
            bus_reset_signal <= 1'b0;
            rdc(A_MSK, k ? 8'h80 : 8'hEF);
            rdc(A_STA, k ? 8'h00 : 8'h40);
            wr(A_STA, 8'h40);
            rdc(A_CTL, c);
            rdc(A_MODE, 8'h05);
        end
        // Serial buffer control
        tx_auto_oe <= 1'b1;
        wr(A_MODE, 8'h00);
        repeat (2) @(posedge clk);
        check("oe auto", serial_out_oe, 1'b1);
        tx_auto_oe <= 1'b0;
        repeat (3) @(posedge clk);
        check("oe auto lo", serial_out_oe, 1'b0);
        wr(A_MODE, 8'h01);
        repeat (2) @(posedge clk);
        check("oe soft", serial_out_oe, 1'b1);
        wr(A_MODE, 8'h03);
        repeat (2) @(posedge clk);
        check("oe off", serial_out_oe, 1'b0);
        // Clock pin: held low, fixed source, baud source
        wr(A_MODE, 8'h08);
        edges(64);
        check("clk off", {cnt[7:0], clock_pin}, 9'h000);
        wr(A_MODE, 8'h0C);
        edges(64);
        check("clk fixed", cnt >= 7, 1'b1);
        wr(A_MODE, 8'hFF);
        rdc(A_MODE, 8'h0F);
        wr(A_MODE, 8'h04);
        edges(64);
        check("clk baud", cnt >= 3 && cnt <= 5, 1'b1);
        // Power-up reset in mid-run returns control and mode to their reset values
        wr(A_CTL, 8'hC1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(A_CTL, 8'h10);
        rdc(A_MODE, 8'h00);
        results();
    end
endmodule

`default_nettype wire
